// *** tb/srs_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host side: classic bus master
// ****************************************
module srs_host_model (
	// Clock
	input wire logic clock,
	// Bus master
	output logic wb_cyc_o,
	output logic wb_stb_o,
	output logic wb_we_o,
	output logic [7:0] wb_adr_o,
	output logic [3:0] wb_sel_o,
	output logic [31:0] wb_dat_o,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_i,
	// Set when no answer came
	output logic timedOut
);
	// Idle bus from time zero
	initial begin
		{wb_cyc_o, wb_stb_o, wb_we_o} = 3'h0;
		wb_adr_o = 8'h00;
		wb_sel_o = 4'h0;
		wb_dat_o = 32'h0;
		timedOut = 1'b0;
	end
	// One cycle, held until ack is sampled high
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
		int n;
		@(posedge clock);
		{wb_cyc_o, wb_stb_o, wb_we_o} <= {2'b11, we};
		wb_adr_o <= a;
		wb_sel_o <= 4'hf;
		wb_dat_o <= d;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack_i !== 1'b1 && n < 40);
		// A bounded wait, the bench decides what a hang means
		timedOut = (wb_ack_i !== 1'b1);
		rd = wb_dat_i;
		{wb_cyc_o, wb_stb_o, wb_we_o} <= 3'h0;
		// Released data must not look still valid
		wb_dat_o <= ~d;
	endtask
endmodule
`default_nettype wire

// *** tb/srs_read_status_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "srs_cfg.svh"
module srs_read_status_tb;
	// ****************************************
	// Signals and model state
	// ****************************************
	logic clock, rstn, wbCyc, wbStb, wbWe, wbAck, hung, irq;
	logic [31:0] wbDatI, wbDatO, seed, rd, srch;
	logic [7:0] wbAdr, rxRawChar;
	logic [3:0] wbSel, rxFieldBits;
	logic rxValid, rxReady, rxEof, txAllClear, txActive, txControlsLoop, loopInserted;
	logic dpllEdgeSeen, dpllEdgeMissed, dpllEnterSearch;
	logic [2:0] rxResidueCode, intVectStatus;
	logic [5:0] intPendBits;
	int failCount, nChecks, i, j;
	int mdl[int]; // Last written value per offset
	logic [7:0] rxq[$]; // Characters expected at the host
	// Free running clock
	always #20 clock = ~clock;
	srs_read_status srs_read_status_inst (.clock(clock), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
		.wb_ack_o(wbAck), .rxValid(rxValid), .rxReady(rxReady), .rxRawChar(rxRawChar),
		.rxFieldBits(rxFieldBits), .rxEof(rxEof), .rxResidueCode(rxResidueCode), .txAllClear(txAllClear),
		.txActive(txActive), .txControlsLoop(txControlsLoop), .loopInserted(loopInserted),
		.dpllEdgeSeen(dpllEdgeSeen), .dpllEdgeMissed(dpllEdgeMissed), .dpllEnterSearch(dpllEnterSearch),
		.intPendBits(intPendBits), .intVectStatus(intVectStatus), .irq(irq));
	srs_host_model srs_host_model_inst (.clock(clock), .wb_cyc_o(wbCyc), .wb_stb_o(wbStb), .wb_we_o(wbWe),
		.wb_adr_o(wbAdr), .wb_sel_o(wbSel), .wb_dat_o(wbDatI), .wb_dat_i(wbDatO), .wb_ack_i(wbAck),
		.timedOut(hung));
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Channel B vector: status code replaces three bits
	function automatic logic [7:0] vecB(input logic [7:0] v, input logic hi, input logic [5:0] p);
		logic [2:0] s;
		s = (p == 6'h0) ? 3'h3 : intVectStatus;
		return hi ? {v[7], s[0], s[1], s[2], v[3:0]} : {v[7:4], s, v[0]};
	endfunction
	task automatic stop_test;
		$display("checks %0d mismatches %0d", nChecks, failCount);
		if (failCount == 0 && nChecks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
		nChecks++;
		if (seen !== e) begin
			failCount++;
			$display("[ERR] %s expected %h seen %h", nm, e, seen);
		end
	endtask
	task automatic xf(input logic we, input logic [7:0] a, input logic [31:0] d);
		if (we) begin
			mdl[a] = d;
		end
		srs_host_model_inst.xfer(we, a, d, rd);
		// A missing ack ends the run
		if (hung) begin
			failCount++;
			stop_test();
		end
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		xf(1'b0, a, 32'h0);
		chk(nm, rd, e);
	endtask
	// Offer one character for one clock edge, without waiting on rxReady
	task automatic send(input logic [7:0] c, input logic [3:0] n, input logic eof, input logic [2:0] res);
		rxRawChar <= c;
		rxFieldBits <= n;
		rxEof <= eof;
		rxResidueCode <= res;
		rxValid <= 1'b1;
		@(posedge clock);
		rxValid <= 1'b0;
		rxq.push_back((n == 4'h8) ? c : c >> (4'h8 - n));
		@(negedge clock);
	endtask
	// One recovery event pulse, then count search pulses
	task automatic pulse(input logic seen);
		@(posedge clock);
		dpllEdgeSeen <= seen;
		dpllEdgeMissed <= !seen;
		@(posedge clock);
		{dpllEdgeSeen, dpllEdgeMissed} <= 2'b00;
		srch = 0;
		repeat (3) begin
			@(negedge clock);
			srch = srch + {31'h0, dpllEnterSearch};
		end
	endtask
	// ****************************************
	// Watchdog and main sequence
	// ****************************************
	initial begin
		repeat (60000) @(posedge clock);
		failCount++;
		stop_test();
	end
	initial begin
		clock = 1'b0;
		rstn = 1'b0;
		{rxValid, rxEof, txAllClear, txActive, txControlsLoop, loopInserted, dpllEdgeSeen, dpllEdgeMissed} = 8'h0;
		{rxRawChar, rxFieldBits, rxResidueCode, intPendBits, intVectStatus} = 24'h0;
		{failCount, nChecks} = 0;
		seed = 32'h6192;
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		// Reset contents, a write to a read-only place, an unmapped read
		rdc("baudHi", `SRS_OFF_BAUDHI_RB, `SRS_BAUD_RST);
		rdc("enables", `SRS_OFF_LEE_RB, `SRS_LEE_RST & `SRS_LEE_USED);
		rdc("rxCond", `SRS_OFF_RX_COND, 32'h6);
		xf(1'b1, `SRS_OFF_VECT_RB, 32'h5a);
		rdc("vector", `SRS_OFF_VECT_RB, `SRS_VECT_RST);
		rdc("unmapped", 8'h7c, 32'h0);
		$display("reset test done");
		// Stored bytes, channel B status, pending flags
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			xf(1'b1, `SRS_OFF_VECT_WR, seed[7:0]);
			xf(1'b1, `SRS_OFF_BAUDLO_WR, seed[15:8]);
			xf(1'b1, `SRS_OFF_BAUDHI_WR, seed[23:16]);
			xf(1'b1, `SRS_OFF_LEE_WR, seed[31:24]);
			rdc("vectA", `SRS_OFF_VECT_RB, mdl[`SRS_OFF_VECT_WR]);
			rdc("baudLo", `SRS_OFF_BAUDLO_RB, mdl[`SRS_OFF_BAUDLO_WR]);
			rdc("baudHi", `SRS_OFF_BAUDHI_RB, mdl[`SRS_OFF_BAUDHI_WR]);
			rdc("enables", `SRS_OFF_LEE_RB, mdl[`SRS_OFF_LEE_WR] & `SRS_LEE_USED);
			for (j = 0; j < 4; j++) begin
				xf(1'b1, `SRS_OFF_MIC_WR, j[0] ? 32'h10 : 32'h0);
				intPendBits <= j[1] ? (seed[13:8] | 6'h1) : 6'h0;
				intVectStatus <= seed[18:16];
				@(posedge clock);
				rdc("vectB", `SRS_OFF_VECT_RB | 8'h80, vecB(seed[7:0], j[0], intPendBits));
				rdc("pendA", `SRS_OFF_PEND, {2'b00, intPendBits});
				rdc("pendB", `SRS_OFF_PEND | 8'h80, 32'h0);
			end
		end
		$display("readback test done");
		// Full and partial characters with the receive interrupt
		xf(1'b1, `SRS_OFF_IRQ_MASK, 32'h1);
		for (i = 8; i > 1; i--) begin
			seed = lfsr(seed);
			send(seed[7:0], i[3:0], 1'b0, 3'h0);
			chk("rxReady", rxReady, 1'b0);
			chk("irq", irq, 1'b1);
			rdc("char", `SRS_OFF_RX_CHAR, rxq.pop_front());
			xf(1'b1, `SRS_OFF_IRQ_STAT, 32'h1);
			@(negedge clock);
			chk("irq", irq, 1'b0);
			chk("rxReady", rxReady, 1'b1);
		end
		// Residue codes, valid only with end of frame
		xf(1'b1, `SRS_OFF_MODE, 32'h2);
		for (i = 0; i < 8; i++) begin
			send(8'ha5, 4'h8, i[0], i[2:0]);
			rdc("rxCond", `SRS_OFF_RX_COND, i[0] ? {24'h0, 4'h8, i[2:0], 1'b1} : 32'h7);
			rdc("char", `SRS_OFF_RX_CHAR, rxq.pop_front());
		end
		// All-sent per framing mode
		for (i = 0; i < 6; i++) begin
			xf(1'b1, `SRS_OFF_MODE, i / 2);
			txAllClear <= i[0];
			@(posedge clock);
			xf(1'b0, `SRS_OFF_RX_COND, 32'h0);
			chk("allSent", rd[0], (i > 1) | i[0]);
		end
		rdc("rxCond", `SRS_OFF_RX_COND, 32'h7);
		$display("receive test done");
		// Missing clock flags, search entry, clearing commands
		xf(1'b1, `SRS_OFF_MODE, 32'hc);
		pulse(1'b0);
		rdc("misc", `SRS_OFF_MISC, 32'h80);
		rdc("misc", `SRS_OFF_MISC, 32'h80);
		pulse(1'b0);
		chk("search", srch, 32'h1);
		rdc("misc", `SRS_OFF_MISC, 32'hc0);
		xf(1'b1, `SRS_OFF_CMD, 32'h1);
		rdc("misc", `SRS_OFF_MISC, 32'h0);
		pulse(1'b0);
		pulse(1'b1);
		pulse(1'b0);
		chk("search", srch, 32'h0);
		rdc("misc", `SRS_OFF_MISC, 32'h80);
		xf(1'b1, `SRS_OFF_CMD, 32'h2);
		rdc("misc", `SRS_OFF_MISC, 32'h0);
		pulse(1'b0);
		xf(1'b1, `SRS_OFF_MODE, 32'h8);
		rdc("misc", `SRS_OFF_MISC, 32'h0);
		pulse(1'b0);
		rdc("misc", `SRS_OFF_MISC, 32'h0);
		$display("recovery test done");
		// Loop flags in loop mode, X.21 and plain async
		for (i = 0; i < 24; i++) begin
			xf(1'b1, `SRS_OFF_MODE, (i < 8) ? 32'h12 : (i < 16) ? 32'h21 : 32'h0);
			{loopInserted, txControlsLoop, txActive} <= i[2:0];
			@(posedge clock);
			rdc("misc", `SRS_OFF_MISC, (i < 8) ? {i[1] & i[0], 2'b00, i[2], 1'b0} :
				(i < 16) ? {i[0], 1'b0} : 32'h0);
		end
		$display("loop test done");
		stop_test();
	end
endmodule
`default_nettype wire

// *** verilog/srs_cfg.svh ***
`ifndef SRS_CFG_SVH
`define SRS_CFG_SVH
// ****************************************
// Register byte offsets (channel A view)
// ****************************************
`define SRS_OFF_VECT_WR 8'h00
`define SRS_OFF_MIC_WR 8'h04
`define SRS_OFF_MODE 8'h08
`define SRS_OFF_CMD 8'h0c
`define SRS_OFF_BAUDLO_WR 8'h10
`define SRS_OFF_BAUDHI_WR 8'h14
`define SRS_OFF_LEE_WR 8'h18
`define SRS_OFF_IRQ_STAT 8'h1c
`define SRS_OFF_IRQ_MASK 8'h20
`define SRS_OFF_RX_COND 8'h24
`define SRS_OFF_VECT_RB 8'h28
`define SRS_OFF_PEND 8'h2c
`define SRS_OFF_RX_CHAR 8'h30
`define SRS_OFF_MISC 8'h34
`define SRS_OFF_BAUDLO_RB 8'h38
`define SRS_OFF_BAUDHI_RB 8'h3c
`define SRS_OFF_LEE_RB 8'h40
// Address bit that selects the channel B view
`define SRS_CHB_BIT 7
// ****************************************
// Field positions
// ****************************************
`define SRS_MIC_STAT_HI 4
`define SRS_MODE_LO 0
`define SRS_MODE_FM 2
`define SRS_MODE_DPLL_EN 3
`define SRS_MODE_LOOP 4
`define SRS_MODE_X21 5
`define SRS_CMD_RST_MISS 0
`define SRS_CMD_SEARCH 1
`define SRS_MISC_ONE_MISS 7
`define SRS_MISC_TWO_MISS 6
`define SRS_MISC_LOOP_SEND 4
`define SRS_MISC_ON_LOOP 1
`define SRS_EV_RX 0
`define SRS_EV_ONE_MISS 1
`define SRS_EV_TWO_MISS 2
`define SRS_EV_ALL_SENT 3
// ****************************************
// Reset values and constant patterns
// ****************************************
`define SRS_RESIDUE_IDLE 3'h3
`define SRS_NOPEND_LOW 3'h3
`define SRS_LEE_USED 8'hfa
`define SRS_PEND_USED 8'h3f
`define SRS_VECT_RST 8'h00
`define SRS_BAUD_RST 8'h00
`define SRS_LEE_RST 8'hf8
`endif

// *** verilog/srs_pkg.sv ***
`default_nettype none
package srs_pkg;
	// Serial framing mode
	typedef enum logic [1:0] {
		SRS_ASYNC = 2'b00,
		SRS_SYNC = 2'b01,
		SRS_SDLC = 2'b10
	} srs_mode_t;
endpackage
`default_nettype wire

// *** verilog/srs_read_status.sv ***
// Functional notes
// - Residue I-field bits right-justified in last character
// - Residue code valid only with end-of-frame
// - Async all-sent set when transmitter fully empty
// - Sync and SDLC: all-sent always set
// - Channel A vector readback returns written vector
// - Channel B vector carries status, high/low select
// - No pending interrupt: status 011 or 110
// - Pending flags only channel A, B reads zero
// - Two unused pending bits read zero
// - Received character register delivers receive data
// - Unassigned misc status bits read zero
// - FM one-missing-clock flag latched until command
// - Two misses set flag, enter search mode
// - Missing-clock flags zero in NRZI or disabled
// - Loop-sending only while transmitter controls loop
// - On-loop in SDLC loop, or X.21 active
// - Baud divisor readbacks return written bytes
// - Enable readback, two unused bits zero
//
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "srs_cfg.svh"
`default_nettype none
module srs_read_status (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Receiver side
	input wire logic rxValid,
	output logic rxReady,
	input wire logic [7:0] rxRawChar,
	input wire logic [3:0] rxFieldBits,
	input wire logic rxEof,
	input wire logic [2:0] rxResidueCode,
	// Transmitter and loop state
	input wire logic txAllClear,
	input wire logic txActive,
	input wire logic txControlsLoop,
	input wire logic loopInserted,
	// Clock recovery loop events
	input wire logic dpllEdgeSeen,
	input wire logic dpllEdgeMissed,
	output logic dpllEnterSearch,
	// Interrupt sources
	input wire logic [5:0] intPendBits,
	input wire logic [2:0] intVectStatus,
	// Interrupt output
	output logic irq
);
	// ****************************************
	// Helper functions
	// ****************************************
	// Shift a left-aligned partial character down to bit 0
	function automatic logic [7:0] justify(input logic [7:0] raw, input logic [3:0] nBits);
		logic [3:0] sh;
		sh = 4'h0;
		if (nBits != 4'h0 && nBits < 4'h8)
			sh = 4'h8 - nBits;
		return raw >> sh;
	endfunction
	// Address match ignoring the channel bit
	function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
		return {1'b0, adr[6:0]} == off;
	endfunction

	// ****************************************
	// Bus slave
	// ****************************************
	logic busReq;
	logic ackGive;
	logic chanB;
	assign busReq = wb_cyc_i && wb_stb_i;
	// Answer one cycle after the request, drop the cycle after
	assign ackGive = busReq && !wb_ack_o;
	assign chanB = wb_adr_i[`SRS_CHB_BIT];
	logic wrStb;
	// Writes take effect on the edge that samples ack high
	assign wrStb = busReq && wb_ack_o && wb_we_i && wb_sel_i[0];
	// Ack register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= ackGive;
	end

	// ****************************************
	// Write registers
	// ****************************************
	logic [7:0] vect_reg; // Interrupt vector
	logic statHi_reg; // Status high/low selection
	logic [5:0] mode_reg; // Mode configuration
	logic [7:0] baudLo_reg;
	logic [7:0] baudHi_reg;
	logic [7:0] lee_reg; // Line event enables
	logic [3:0] irqMask_reg;
	srs_pkg::srs_mode_t mode;
	assign mode = srs_pkg::srs_mode_t'(mode_reg[`SRS_MODE_LO +: 2]);
	// Stored values only change by writes, never by reads
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			vect_reg <= `SRS_VECT_RST;
			statHi_reg <= 1'b0;
			mode_reg <= 6'h00;
			baudLo_reg <= `SRS_BAUD_RST;
			baudHi_reg <= `SRS_BAUD_RST;
			lee_reg <= `SRS_LEE_RST;
			irqMask_reg <= 4'h0;
		end else if (wrStb) begin
			if (hit(wb_adr_i, `SRS_OFF_VECT_WR))
				vect_reg <= wb_dat_i[7:0];
			if (hit(wb_adr_i, `SRS_OFF_MIC_WR))
				statHi_reg <= wb_dat_i[`SRS_MIC_STAT_HI];
			if (hit(wb_adr_i, `SRS_OFF_MODE))
				mode_reg <= wb_dat_i[5:0];
			if (hit(wb_adr_i, `SRS_OFF_BAUDLO_WR))
				baudLo_reg <= wb_dat_i[7:0];
			if (hit(wb_adr_i, `SRS_OFF_BAUDHI_WR))
				baudHi_reg <= wb_dat_i[7:0];
			if (hit(wb_adr_i, `SRS_OFF_LEE_WR))
				lee_reg <= wb_dat_i[7:0] & `SRS_LEE_USED;
			if (hit(wb_adr_i, `SRS_OFF_IRQ_MASK))
				irqMask_reg <= wb_dat_i[3:0];
		end
	end
	// Command strobes, self clearing
	logic cmdRstMiss;
	logic cmdSearch;
	assign cmdRstMiss = wrStb && hit(wb_adr_i, `SRS_OFF_CMD) && wb_dat_i[`SRS_CMD_RST_MISS];
	assign cmdSearch = wrStb && hit(wb_adr_i, `SRS_OFF_CMD) && wb_dat_i[`SRS_CMD_SEARCH];

	// ****************************************
	// Receive character holding register
	// ****************************************
	logic [7:0] rxChar_reg;
	logic rxFull_reg;
	logic rxEof_reg;
	logic [2:0] residue_reg;
	logic rxRead;
	logic rxLoad;
	// Only a read of the character consumes it
	assign rxRead = ackGive && !wb_we_i && !chanB && hit(wb_adr_i, `SRS_OFF_RX_CHAR);
	assign rxReady = !rxFull_reg;
	assign rxLoad = rxValid && !rxFull_reg;
	// Full flag: a new load wins over a same-cycle read, read empties
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			rxFull_reg <= 1'b0;
		else if (rxLoad)
			rxFull_reg <= 1'b1;
		else if (rxRead)
			rxFull_reg <= 1'b0;
	end
	// Data, end of frame and residue captured together
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rxChar_reg <= 8'h00;
			rxEof_reg <= 1'b0;
			residue_reg <= `SRS_RESIDUE_IDLE;
		end else if (rxLoad) begin
			rxChar_reg <= justify(rxRawChar, rxFieldBits);
			rxEof_reg <= rxEof && (mode == srs_pkg::SRS_SDLC);
			// Residue is only meaningful with end of frame
			residue_reg <= (rxEof && mode == srs_pkg::SRS_SDLC) ? rxResidueCode : `SRS_RESIDUE_IDLE;
		end else if (mode != srs_pkg::SRS_SDLC) begin
			// Outside SDLC the frame end drops and the residue idles
			rxEof_reg <= 1'b0;
			residue_reg <= `SRS_RESIDUE_IDLE;
		end
	end

	// ****************************************
	// All sent
	// ****************************************
	logic allSent;
	// Async follows transmitter, framed modes always set
	assign allSent = (mode == srs_pkg::SRS_ASYNC) ? txAllClear : 1'b1;

	// ****************************************
	// Clock recovery missing-clock flags
	// ****************************************
	logic fmOn;
	logic oneMiss_reg;
	logic twoMiss_reg;
	logic prevMiss_reg;
	logic secondMiss;
	assign fmOn = mode_reg[`SRS_MODE_FM] && mode_reg[`SRS_MODE_DPLL_EN];
	assign secondMiss = fmOn && dpllEdgeMissed && prevMiss_reg;
	// Remembers a miss until an edge is seen
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			prevMiss_reg <= 1'b0;
		// Search restarts the miss count, so one later miss is not a second
		else if (!fmOn || dpllEdgeSeen || secondMiss || cmdSearch)
			prevMiss_reg <= 1'b0;
		else if (dpllEdgeMissed)
			prevMiss_reg <= 1'b1;
	end
	// Latched flags; a new miss wins over the clearing command
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			oneMiss_reg <= 1'b0;
			twoMiss_reg <= 1'b0;
		end else begin
			if (fmOn && dpllEdgeMissed)
				oneMiss_reg <= 1'b1;
			else if (cmdRstMiss || cmdSearch)
				oneMiss_reg <= 1'b0;
			if (secondMiss)
				twoMiss_reg <= 1'b1;
			else if (cmdRstMiss || cmdSearch)
				twoMiss_reg <= 1'b0;
		end
	end
	// Search mode entered on two misses or by command
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			dpllEnterSearch <= 1'b0;
		else
			dpllEnterSearch <= secondMiss || cmdSearch;
	end

	// ****************************************
	// Status compositions
	// ****************************************
	logic [7:0] misc;
	logic [2:0] vStat;
	logic [7:0] vectB;
	logic [7:0] rxCond;
	always_comb begin
		misc = 8'h00; // Unassigned bits zero
		// Hidden outside FM with the loop enabled
		misc[`SRS_MISC_ONE_MISS] = oneMiss_reg && fmOn;
		misc[`SRS_MISC_TWO_MISS] = twoMiss_reg && fmOn;
		misc[`SRS_MISC_LOOP_SEND] = mode_reg[`SRS_MODE_LOOP] && mode == srs_pkg::SRS_SDLC
			&& txActive && txControlsLoop;
		misc[`SRS_MISC_ON_LOOP] = (mode_reg[`SRS_MODE_LOOP] && mode == srs_pkg::SRS_SDLC && loopInserted)
			|| (mode_reg[`SRS_MODE_X21] && txActive);
	end
	always_comb begin
		// No pending source gives the idle code
		vStat = (intPendBits == 6'h00) ? `SRS_NOPEND_LOW : intVectStatus;
		vectB = vect_reg;
		// Insert status by the high/low select only
		if (statHi_reg)
			vectB[6:4] = {vStat[0], vStat[1], vStat[2]};
		else
			vectB[3:1] = vStat;
	end
	assign rxCond = {rxEof_reg, 3'h0, residue_reg, allSent};

	// ****************************************
	// Interrupt status and output
	// ****************************************
	logic [3:0] irqStat_reg;
	logic [3:0] events;
	logic allSentPrev_reg;
	logic [3:0] w1c;
	assign events[`SRS_EV_RX] = rxLoad;
	assign events[`SRS_EV_ONE_MISS] = fmOn && dpllEdgeMissed;
	assign events[`SRS_EV_TWO_MISS] = secondMiss;
	assign events[`SRS_EV_ALL_SENT] = allSent && !allSentPrev_reg;
	assign w1c = (wrStb && hit(wb_adr_i, `SRS_OFF_IRQ_STAT)) ? wb_dat_i[3:0] : 4'h0;
	// Rising edge detect of all sent
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			allSentPrev_reg <= 1'b1;
		else
			allSentPrev_reg <= allSent;
	end
	// Sticky bits; a same-cycle event wins over the clear
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			irqStat_reg <= 4'h0;
		else
			irqStat_reg <= (irqStat_reg & ~w1c) | events;
	end
	assign irq = |(irqStat_reg & irqMask_reg);

	// ****************************************
	// Read data
	// ****************************************
	logic [7:0] rdMux;
	always_comb begin
		rdMux = 8'h00; // Unmapped reads zero
		unique case (1'b1)
			hit(wb_adr_i, `SRS_OFF_MODE): rdMux = {2'h0, mode_reg};
			hit(wb_adr_i, `SRS_OFF_IRQ_STAT): rdMux = {4'h0, irqStat_reg};
			hit(wb_adr_i, `SRS_OFF_IRQ_MASK): rdMux = {4'h0, irqMask_reg};
			hit(wb_adr_i, `SRS_OFF_RX_COND): rdMux = rxCond;
			hit(wb_adr_i, `SRS_OFF_VECT_RB): rdMux = chanB ? vectB : vect_reg;
			hit(wb_adr_i, `SRS_OFF_PEND):
				rdMux = chanB ? 8'h00 : ({2'h0, intPendBits} & `SRS_PEND_USED);
			hit(wb_adr_i, `SRS_OFF_RX_CHAR): rdMux = rxChar_reg;
			hit(wb_adr_i, `SRS_OFF_MISC): rdMux = misc;
			hit(wb_adr_i, `SRS_OFF_BAUDLO_RB): rdMux = baudLo_reg;
			hit(wb_adr_i, `SRS_OFF_BAUDHI_RB): rdMux = baudHi_reg;
			hit(wb_adr_i, `SRS_OFF_LEE_RB): rdMux = lee_reg;
			default: rdMux = 8'h00;
		endcase
	end
	// Data captured with ack so it stands while ack is high
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			wb_dat_o <= 32'h0;
		else if (ackGive && !wb_we_i)
			wb_dat_o <= {24'h0, rdMux};
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
	chan_a_vect_a: assert property (ackGive && !wb_we_i && !chanB && hit(wb_adr_i, `SRS_OFF_VECT_RB)
		|=> wb_dat_o[7:0] == vect_reg) else $error("channel A vector altered");
	idle_stat_a: assert property (!statHi_reg && intPendBits == 6'h00 |-> vectB[3:1] == 3'h3)
		else $error("idle vector status wrong");
	chan_b_pend_a: assert property (ackGive && !wb_we_i && chanB && hit(wb_adr_i, `SRS_OFF_PEND)
		|=> wb_dat_o == 32'h0) else $error("channel B pending not zero");
	sync_sent_a: assert property (mode != srs_pkg::SRS_ASYNC |-> rxCond[0])
		else $error("all sent clear outside async");
	nrzi_miss_a: assert property (!fmOn |-> misc[7:6] == 2'h0)
		else $error("missing clock flag outside FM");
	one_miss_hold_a: assert property (oneMiss_reg && !cmdRstMiss && !cmdSearch |=> oneMiss_reg)
		else $error("missing clock flag lost");
	two_miss_a: assert property (secondMiss |=> twoMiss_reg && dpllEnterSearch)
		else $error("second miss not flagged");
	lee_unused_a: assert property ((lee_reg & ~`SRS_LEE_USED) == 8'h00)
		else $error("unused enable bits set");
	read_keep_a: assert property (ackGive && !wb_we_i && !hit(wb_adr_i, `SRS_OFF_RX_CHAR) && !rxLoad
		|=> $stable(rxFull_reg)) else $error("read changed receive state");
	eof_residue_a: assert property (!rxEof_reg |-> residue_reg == 3'h3)
		else $error("residue valid without end of frame");
	cov_rx_read_c: cover property (rxLoad ##[1:20] rxRead);
	cov_two_miss_c: cover property (secondMiss);
	cov_b_vect_c: cover property (ackGive && chanB && hit(wb_adr_i, `SRS_OFF_VECT_RB) && statHi_reg);
	cov_irq_c: cover property ($rose(irq));
endmodule
`default_nettype wire
